//--- core/cig_consts.vh
// constants for the cpu interrupt gating block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef CIG_CONSTS_VH
`define CIG_CONSTS_VH
`define CIG_OFS_PENDING 12'h000
`define CIG_OFS_MASK 12'h004
`define CIG_OFS_STATUS0 12'h008
`define CIG_OFS_SWINT 12'h00C
`define CIG_OFS_ACK 12'h010
`define CIG_OFS_VECTOR 12'h014
`define CIG_OFS_PC 12'h018
`define CIG_OFS_EVSTAT 12'h01C
`define CIG_OFS_EVCLR 12'h020
`define CIG_OFS_EVEN 12'h024
`define CIG_OFS_VBASE 12'h028
`define CIG_GID_BIT 9
`define CIG_NMI_IDX 0
`define CIG_RST_MASK 16'h0000
`define CIG_RST_STATUS0 16'h0200
`define CIG_RST_VBASE 16'h0000
`define CIG_EV_REQ 0
`define CIG_EV_ACK 1
`define CIG_EV_W 2
`endif

//--- core/cig_sync.v
// two-flop synchroniser for a bus of asynchronous pin levels
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module cig_sync #(
    parameter W = 4
) (
    input wire clk_in,
    input wire nrst_in,
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] stage1; // first flop, read only by stage2
    reg [W-1:0] stage2; // settled copy
    // shift pins through two flops
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
        end else begin
            stage1 <= d_in;
            stage2 <= stage1;
        end
    end
    assign q_out = stage2;
endmodule
`default_nettype wire

//--- core/cig_top.v
// cpu interrupt gating: pending flags, mask, global gate, vectoring
// assumes an apb master on CLK_SYS_IN and a cpu that acknowledges requests
//
// Overview of operation
// [RULE1] 16-bit readable pending flag register
// [RULE2] writing one clears a pending flag
// [RULE3] 16-bit enable mask, one enables source
// [RULE4] status bit 9 set blocks maskables
// [RULE5] non-maskable request bypasses mask and gate
// [RULE6] acknowledge jumps to source vector address
// [RULE7] sources: pins, peripherals, software instructions
// [RULE8] pending holds until cpu acknowledges
// [RULE9] only program counter saved and restored
// [RULE10] flags set regardless of mask, auto clear
//
// Added by the designer: the APB register port and the register addresses.
`include "cig_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module cig_top #(
    parameter NPIN = 4,
    parameter NPER = 11,
    parameter VSTEP = 2
) (
    input wire CLK_SYS_IN,
    input wire NRST_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    input wire [NPIN-1:0] EXT_IRQ_PIN_IN,
    input wire [NPER-1:0] PERIPH_IRQ_IN,
    input wire CPU_ACK_IN,
    input wire CPU_RETURN_IN,
    input wire [15:0] CPU_PC_IN,
    output reg CPU_IRQ_OUT,
    output reg [3:0] CPU_IRQ_ID_OUT,
    output reg [15:0] CPU_VECTOR_OUT,
    output reg CPU_VECTOR_LOAD_OUT,
    output reg [15:0] CPU_RESTORE_PC_OUT,
    output reg CPU_RESTORE_LOAD_OUT,
    output wire IRQ_OUT
);
    // source map: bit 0 nmi, pins above it, peripherals above those
    localparam NSRC = 16;
    localparam PIN_LO = 1;
    localparam PER_LO = PIN_LO + NPIN;

    wire [NPIN-1:0] pin_sync; // synchronised pin levels
    reg [NPIN-1:0] pin_prev; // last settled pin level
    reg [NPER-1:0] per_prev; // last peripheral level
    reg [15:0] pending_flag_reg; // latched requests
    reg [15:0] enable_mask_reg; // per-source enables
    reg [15:0] status_word_zero; // holds global gate
    reg [15:0] vector_base; // program address of vector table
    reg [15:0] saved_pc; // return address
    reg [`CIG_EV_W-1:0] ev_stat; // sticky events
    reg [`CIG_EV_W-1:0] ev_en; // event enables
    reg [15:0] hw_req; // one-cycle hardware request
    reg [15:0] sw_req; // one-cycle software request
    reg [15:0] ack_clr; // one-cycle clear on acknowledge
    reg [15:0] w1c; // one-cycle software clear
    reg [15:0] next_pending; // next flag value
    reg [15:0] eligible; // serviceable flags
    reg [3:0] next_id; // winning source
    reg next_valid; // some source wins
    reg [3:0] in_svc_id; // id being acknowledged
    reg ack_prev; // ack edge detect
    wire global_int_disable; // gate bit of status word
    wire wr_en; // write strobe in access phase
    wire rd_en; // read strobe in access phase
    wire ack_rise; // new acknowledge
    reg addr_ok; // address decodes
    integer i; // loop index of the request edge detector only
    integer j; // loop index of the priority search only

    assign global_int_disable = status_word_zero[`CIG_GID_BIT];
    assign PREADY_OUT = 1'b1; // zero wait states
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
    assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
    assign rd_en = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
    assign ack_rise = CPU_ACK_IN & ~ack_prev;
    assign IRQ_OUT = |(ev_stat & ev_en);

    // external pins pass two flops first
    cig_sync #(
        .W(NPIN)
    ) u_pin_sync (
        .clk_in(CLK_SYS_IN),
        .nrst_in(NRST_IN),
        .d_in(EXT_IRQ_PIN_IN),
        .q_out(pin_sync)
    );

    // address decode
    always @* begin
        case (PADDR_IN)
            `CIG_OFS_PENDING, `CIG_OFS_MASK, `CIG_OFS_STATUS0, `CIG_OFS_SWINT,
            `CIG_OFS_ACK, `CIG_OFS_VECTOR, `CIG_OFS_PC, `CIG_OFS_EVSTAT,
            `CIG_OFS_EVCLR, `CIG_OFS_EVEN, `CIG_OFS_VBASE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // rising-edge request detection on pins and peripherals
    always @* begin
        hw_req = 16'h0000;
        for (i = 0; i < NPIN; i = i + 1) begin
            hw_req[PIN_LO + i] = pin_sync[i] & ~pin_prev[i]; // see [RULE7]
        end
        for (i = 0; i < NPER; i = i + 1) begin
            hw_req[PER_LO + i] = PERIPH_IRQ_IN[i] & ~per_prev[i]; // see [RULE7]
        end
    end

    // software interrupt instruction raises the chosen flag
    always @* begin
        sw_req = 16'h0000;
        if (wr_en && PADDR_IN == `CIG_OFS_SWINT) begin
            sw_req[PWDATA_IN[3:0]] = 1'b1; // software_interrupt_op, see [RULE7]
        end
    end

    // write-one-to-clear from software
    always @* begin
        w1c = 16'h0000;
        if (wr_en && PADDR_IN == `CIG_OFS_PENDING) begin
            w1c = PWDATA_IN[15:0]; // see [RULE2]
        end
    end

    // acknowledge clears the serviced flag
    always @* begin
        ack_clr = 16'h0000;
        if (ack_rise && CPU_IRQ_OUT) begin
            ack_clr[CPU_IRQ_ID_OUT] = 1'b1; // see [RULE10]
        end
    end

    // flags set ignoring mask, set wins over clear
    always @* begin
        next_pending = (pending_flag_reg & ~(w1c | ack_clr)) | hw_req | sw_req; // see [RULE10]
    end

    // gating: mask and global gate, nmi bypasses both
    always @* begin
        eligible = pending_flag_reg & enable_mask_reg & {16{~global_int_disable}}; // see [RULE3]
        eligible[`CIG_NMI_IDX] = pending_flag_reg[`CIG_NMI_IDX]; // see [RULE5]
    end

    // lowest index wins priority
    always @* begin
        next_id = 4'h0;
        next_valid = 1'b0;
        for (j = NSRC - 1; j >= 0; j = j - 1) begin
            if (eligible[j]) begin
                next_id = j[3:0];
                next_valid = 1'b1;
            end
        end
    end

    // pending flags, edge history
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pending_flag_reg <= 16'h0000;
            pin_prev <= {NPIN{1'b0}};
            per_prev <= {NPER{1'b0}};
            ack_prev <= 1'b0;
        end else begin
            pending_flag_reg <= next_pending; // held until ack or clear, see [RULE8]
            pin_prev <= pin_sync;
            per_prev <= PERIPH_IRQ_IN;
            ack_prev <= CPU_ACK_IN;
        end
    end

    // software-written control registers
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            enable_mask_reg <= `CIG_RST_MASK;
            status_word_zero <= `CIG_RST_STATUS0;
            vector_base <= `CIG_RST_VBASE;
            ev_en <= {`CIG_EV_W{1'b0}};
        end else if (wr_en) begin
            case (PADDR_IN)
                `CIG_OFS_MASK: enable_mask_reg <= PWDATA_IN[15:0]; // see [RULE3]
                `CIG_OFS_STATUS0: status_word_zero <= PWDATA_IN[15:0]; // see [RULE4]
                `CIG_OFS_VBASE: vector_base <= PWDATA_IN[15:0];
                `CIG_OFS_EVEN: ev_en <= PWDATA_IN[`CIG_EV_W-1:0];
                default: ev_en <= ev_en;
            endcase
        end
    end

    // request to cpu, registered
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CPU_IRQ_OUT <= 1'b0;
            CPU_IRQ_ID_OUT <= 4'h0;
        end else if (ack_rise && CPU_IRQ_OUT) begin
            CPU_IRQ_OUT <= 1'b0; // drop for one cycle after ack
        end else begin
            CPU_IRQ_OUT <= next_valid; // see [RULE4]
            CPU_IRQ_ID_OUT <= next_id;
        end
    end

    // vectoring and program counter save
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CPU_VECTOR_OUT <= 16'h0000;
            CPU_VECTOR_LOAD_OUT <= 1'b0;
            saved_pc <= 16'h0000;
            in_svc_id <= 4'h0;
        end else begin
            CPU_VECTOR_LOAD_OUT <= 1'b0;
            if (ack_rise && CPU_IRQ_OUT) begin
                // vector location = base + id * step, see [RULE6]
                CPU_VECTOR_OUT <= vector_base + ({12'h000, CPU_IRQ_ID_OUT} * VSTEP[15:0]);
                CPU_VECTOR_LOAD_OUT <= 1'b1;
                saved_pc <= CPU_PC_IN; // only the pc is saved, see [RULE9]
                in_svc_id <= CPU_IRQ_ID_OUT;
            end
        end
    end

    // return restores the saved pc
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CPU_RESTORE_PC_OUT <= 16'h0000;
            CPU_RESTORE_LOAD_OUT <= 1'b0;
        end else begin
            CPU_RESTORE_LOAD_OUT <= CPU_RETURN_IN; // see [RULE9]
            if (CPU_RETURN_IN) begin
                CPU_RESTORE_PC_OUT <= saved_pc;
            end
        end
    end

    // sticky events: request latched, acknowledge taken; set wins
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ev_stat <= {`CIG_EV_W{1'b0}};
        end else begin
            if (wr_en && PADDR_IN == `CIG_OFS_EVCLR) begin
                ev_stat <= ev_stat & ~PWDATA_IN[`CIG_EV_W-1:0];
            end
            if (|(hw_req | sw_req)) begin
                ev_stat[`CIG_EV_REQ] <= 1'b1;
            end
            if (ack_rise && CPU_IRQ_OUT) begin
                ev_stat[`CIG_EV_ACK] <= 1'b1;
            end
        end
    end

    // read mux, registered on setup phase
    always @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            PRDATA_OUT <= 32'h00000000;
        end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            case (PADDR_IN)
                `CIG_OFS_PENDING: PRDATA_OUT <= {16'h0000, pending_flag_reg}; // see [RULE1]
                `CIG_OFS_MASK: PRDATA_OUT <= {16'h0000, enable_mask_reg};
                `CIG_OFS_STATUS0: PRDATA_OUT <= {16'h0000, status_word_zero};
                `CIG_OFS_ACK: PRDATA_OUT <= {27'h0000000, in_svc_id, CPU_IRQ_OUT};
                `CIG_OFS_VECTOR: PRDATA_OUT <= {16'h0000, CPU_VECTOR_OUT};
                `CIG_OFS_PC: PRDATA_OUT <= {16'h0000, saved_pc};
                `CIG_OFS_EVSTAT: PRDATA_OUT <= {30'h00000000, ev_stat};
                `CIG_OFS_EVEN: PRDATA_OUT <= {30'h00000000, ev_en};
                `CIG_OFS_VBASE: PRDATA_OUT <= {16'h0000, vector_base};
                default: PRDATA_OUT <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- bench/cig_top_sva.sv
// checker for the bus and cpu side ports of the gating block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module cig_top_sva (
    input wire CLK_SYS_IN,
    input wire NRST_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire [11:0] PADDR_IN,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    input wire CPU_ACK_IN,
    input wire CPU_RETURN_IN,
    input wire CPU_IRQ_OUT,
    input wire [15:0] CPU_VECTOR_OUT,
    input wire CPU_VECTOR_LOAD_OUT,
    input wire CPU_RESTORE_LOAD_OUT
);
    // all checks on the system clock, idle in reset
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!NRST_IN);
    // acknowledge taken at this edge
    sequence s_take;
        $rose(CPU_ACK_IN) && CPU_IRQ_OUT;
    endsequence
    a_ready_high: assert property (PREADY_OUT)
        else $error("pready low");
    a_err_phase: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("slverr outside access");
    a_err_unmapped: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > 12'h028 |-> PSLVERR_OUT)
        else $error("no slverr on unmapped");
    a_ack_loads: assert property (s_take |=> CPU_VECTOR_LOAD_OUT)
        else $error("no vector load after ack");
    a_ack_drops_irq: assert property (s_take |=> !CPU_IRQ_OUT)
        else $error("irq stays after ack");
    a_load_cause: assert property (CPU_VECTOR_LOAD_OUT |->
        $past(CPU_IRQ_OUT) && $past(CPU_ACK_IN) && !$past(CPU_ACK_IN, 2))
        else $error("vector load without ack");
    a_vector_hold: assert property (!CPU_VECTOR_LOAD_OUT |-> $stable(CPU_VECTOR_OUT))
        else $error("vector moved without load");
    a_restore_pulse: assert property (CPU_RESTORE_LOAD_OUT == $past(CPU_RETURN_IN))
        else $error("restore pulse wrong");
endmodule
bind cig_top cig_top_sva cig_top_sva_i (.CLK_SYS_IN, .NRST_IN, .PSEL_IN, .PENABLE_IN,
    .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .CPU_ACK_IN, .CPU_RETURN_IN, .CPU_IRQ_OUT,
    .CPU_VECTOR_OUT, .CPU_VECTOR_LOAD_OUT, .CPU_RESTORE_LOAD_OUT);
`default_nettype wire

//--- bench/test_cpu_interrupt_gating.sv
// self-checking bench for the gating block against a reference model
// assumes apb with no wait states and flags set on request edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, s); end end
module test_cpu_interrupt_gating;
    reg clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ack = 0, ret = 0, se;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, r;
    reg [3:0] pins = 0;
    reg [10:0] per = 0;
    reg [15:0] pc = 0, pend = 0, mask = 0, st0 = 16'h0200, vb = 0, p, c;
    wire [31:0] prdata;
    wire pready, pslverr, irq, vld, rld, irq_out;
    wire [3:0] id;
    wire [15:0] vec, rpc;
    integer seed = 32'h1A3A, err_total = 0, samples_checked = 0, k;
    cig_top cig_top_i (.CLK_SYS_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXT_IRQ_PIN_IN(pins),
        .PERIPH_IRQ_IN(per), .CPU_ACK_IN(ack), .CPU_RETURN_IN(ret), .CPU_PC_IN(pc),
        .CPU_IRQ_OUT(irq), .CPU_IRQ_ID_OUT(id), .CPU_VECTOR_OUT(vec),
        .CPU_VECTOR_LOAD_OUT(vld), .CPU_RESTORE_PC_OUT(rpc), .CPU_RESTORE_LOAD_OUT(rld),
        .IRQ_OUT(irq_out));
    // free-running system clock
    always #4 clk = ~clk;
    // one apb transfer: setup, access until pready, release
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
            @(posedge clk);
            pen <= 1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            r = prdata;
            se = pslverr;
            {psel, pen} <= 2'b00;
            @(posedge clk);
        end
    endtask
    // read and compare one register
    task rd(input [11:0] a, input [31:0] e);
        begin
            apb(0, a, 0);
            `CHK("prdata", e, r)
        end
    endtask
    // serviceable sources: nmi always, others by mask and gate
    function [15:0] svc(input [15:0] f);
        svc = f & (st0[9] ? 16'h0001 : (mask | 16'h0001));
    endfunction
    // lowest index wins
    function [3:0] win(input [15:0] f);
        integer i;
        begin
            win = 0;
            for (i = 15; i >= 0; i = i - 1) if (f[i]) win = i[3:0];
        end
    endfunction
    // cpu request line and winner against the model
    task chk_irq;
        begin
            @(posedge clk);
            `CHK("irq", |svc(pend), irq)
            if (|svc(pend)) `CHK("irq id", win(svc(pend)), id)
        end
    endtask
    task end_of_test;
        begin
            if (err_total == 0 && samples_checked > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #200000;
        err_total = err_total + 1;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        rd(0, 0);
        rd(4, 0);
        rd(8, 32'h0200);
        // unmapped place gives error and zero data
        rd(12'h0FC, 0);
        `CHK("slverr", 1'b1, se)
        // pin edge through the synchroniser
        pins <= 4'h4;
        repeat (5) @(posedge clk);
        pins <= 0;
        pend = 16'h0008;
        rd(0, pend);
        // random mask, gate, peripheral and software requests
        for (k = 0; k < 12; k = k + 1) begin
            mask = $random(seed);
            st0 = $random(seed) & 16'h0200;
            apb(1, 4, mask);
            apb(1, 8, st0);
            p = $random(seed);
            per <= p[10:0];
            @(posedge clk);
            per <= 0;
            apb(1, 12, p[15:12]);
            pend = pend | {p[10:0], 5'h00} | (16'h0001 << p[15:12]);
            rd(0, pend);
            chk_irq;
            c = $random(seed);
            apb(1, 0, c);
            pend = pend & ~c;
            rd(0, pend);
        end
        // nmi passes a closed mask and a set gate
        mask = 0;
        st0 = 16'h0200;
        apb(1, 4, 0);
        apb(1, 8, st0);
        apb(1, 12, 0);
        pend = pend | 16'h0001;
        chk_irq;
        // event status, enable and clear on the level output
        apb(1, 36, 1);
        apb(1, 32, 3);
        apb(1, 12, 5);
        `CHK("irq_out", 1'b1, irq_out)
        apb(1, 32, 1);
        `CHK("irq_out", 1'b0, irq_out)
        apb(1, 36, 0);
        apb(1, 12, 6);
        `CHK("irq_out", 1'b0, irq_out)
        rd(28, 1);
        // acknowledge every source in turn
        mask = 16'hFFFF;
        st0 = 0;
        vb = 16'h0100;
        apb(1, 4, mask);
        apb(1, 8, 0);
        apb(1, 40, vb);
        apb(1, 0, 16'hFFFF);
        for (k = 0; k < 16; k = k + 1) begin
            apb(1, 12, k);
            pend = 16'h0001 << k;
            chk_irq;
            p = $random(seed);
            pc <= p;
            ack <= 1;
            @(posedge clk);
            #1;
            `CHK("load", 1'b1, vld)
            `CHK("vector", vb + 16'h0002 * k[15:0], vec)
            @(posedge clk);
            ack <= 0;
            rd(0, 0);
            rd(24, p);
            ret <= 1;
            @(posedge clk);
            ret <= 0;
            #1;
            `CHK("restore", p, rpc)
            `CHK("restore load", 1'b1, rld)
            @(posedge clk);
        end
        // read-only vector place ignores writes
        apb(1, 20, 0);
        rd(20, vb + 16'h001E);
        end_of_test;
    end
endmodule
`default_nettype wire
